// ---- rtl/sfd_regs.svh ----
`ifndef SFD_REGS_SVH
`define SFD_REGS_SVH

// Opcodes of the single-wire instruction set
`define SFD_OP_ID_READ 8'h9e
`define SFD_OP_READ 8'h03
`define SFD_OP_FAST_READ 8'h0b
`define SFD_OP_DUAL_OUT_RD 8'h3b
`define SFD_OP_DUAL_IO_RD 8'hbb
`define SFD_OP_QUAD_OUT_RD 8'h6b
`define SFD_OP_QUAD_IO_RD 8'heb
`define SFD_OP_OTP_READ 8'h4b
`define SFD_OP_LATCH_SET 8'h06
`define SFD_OP_LATCH_CLR 8'h04
`define SFD_OP_PAGE_PROG 8'h02
`define SFD_OP_DUAL_PROG 8'ha2
`define SFD_OP_DUAL_EXT_PROG 8'hd2
`define SFD_OP_QUAD_PROG 8'h32
`define SFD_OP_QUAD_EXT_PROG 8'h12
`define SFD_OP_OTP_PROG 8'h42
`define SFD_OP_SMALL_ERASE 8'h20
`define SFD_OP_BLOCK_ERASE 8'hd8
`define SFD_OP_CHIP_ERASE 8'hc7
`define SFD_OP_RESUME 8'h7a
`define SFD_OP_SUSPEND 8'h75
`define SFD_OP_STAT_RD 8'h05
`define SFD_OP_STAT_WR 8'h01
`define SFD_OP_LOCK_RD 8'he8
`define SFD_OP_LOCK_WR 8'he5
`define SFD_OP_FLAG_RD 8'h70
`define SFD_OP_FLAG_CLR 8'h50
`define SFD_OP_NVCFG_RD 8'hb5
`define SFD_OP_NVCFG_WR 8'hb1
`define SFD_OP_VCFG_RD 8'h85
`define SFD_OP_VCFG_WR 8'h81
`define SFD_OP_VECFG_RD 8'h65
`define SFD_OP_VECFG_WR 8'h61

// Default dummy clocks
`define SFD_DUMMY_STD 4'h8
`define SFD_DUMMY_QIO 4'ha
// Byte limits
`define SFD_ID_BYTES 9'h014
`define SFD_PAGE_BYTES 9'h100
`define SFD_OTP_BYTES 9'h041
`define SFD_NVCFG_BYTES 9'h002
// Address width in bits
`define SFD_ADDR_BITS 5'h18

`endif

// ---- rtl/sfd_pkg.sv ----
package sfd_pkg;
    // Phase of the current selection
    typedef enum logic [2:0] {
        SFD_PH_OP = 3'b000,
        SFD_PH_ADDR = 3'b001,
        SFD_PH_DUMMY = 3'b010,
        SFD_PH_DIN = 3'b011,
        SFD_PH_DOUT = 3'b100,
        SFD_PH_SKIP = 3'b101
    } sfd_phase_e;

    // Instruction class
    typedef enum logic [2:0] {
        SFD_CL_NONE = 3'b000,
        SFD_CL_READ = 3'b001,
        SFD_CL_MOD = 3'b010,
        SFD_CL_SUSP = 3'b011,
        SFD_CL_RES = 3'b100
    } sfd_class_e;

    // Decoded instruction shape
    typedef struct packed {
        sfd_class_e cls;
        logic array;
        logic has_addr;
        logic [2:0] addr_ln;
        logic [3:0] dummy;
        logic [2:0] data_ln;
        logic unbounded;
        logic [8:0] min_b;
        logic [8:0] max_b;
    } sfd_info_s;

    // Byte reference: opcode, address, byte index
    typedef struct packed {
        logic [7:0] op;
        logic [23:0] addr;
        logic [8:0] idx;
    } sfd_ref_s;

    // Incoming data byte
    typedef struct packed {
        sfd_ref_s at;
        logic [7:0] data;
    } sfd_byte_s;

    // Finished modify instruction
    typedef struct packed {
        logic [7:0] op;
        logic [23:0] addr;
        logic [8:0] nbytes;
        logic ok;
    } sfd_cmd_s;
endpackage

// ---- rtl/sfd_decoder.sv ----
// How it works
// - Opcode always arrives on serial_io0 alone
// - Reads output data, deselect allowed any bit
// - Modify instructions need deselect after a multiple of eight clocks
// - Array access ignored during internal cycles
// - Internal cycles unaffected except by suspend
// - Suspend pauses program/erase, not others
// - Resume continues suspended cycle, opcode only
// - Status and flag reads accepted while busy
// - Plain read 03h, fast read 0Bh
// - Dual reads 3Bh and BBh, eight dummies
// - Quad reads 6Bh eight, EBh ten dummies
// - Identification 9Eh/9Fh, one to twenty bytes
// - Write latch set 06h, clear 04h
// - Page programs, three address bytes, 1-256
// - OTP read 4Bh, program 42h, 1-65
// - Erases 20h, D8h with address; C7h none
// - Status read repeats; write one byte
// - Flag read repeats; clear is opcode only
// - Lock read/write with three address bytes
// - Non-volatile config read/write two bytes
// - Volatile config read repeats; write one
// - Enhanced config read repeats; write one
// - All fields travel most significant first
// - Bits captured on rising serial clock
`timescale 1ns/1ps
`default_nettype none
`include "sfd_regs.svh"

module sfd_decoder (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_io,
    output logic [3:0] o_io_out,
    output logic [3:0] o_io_oe,
    input wire logic i_busy,
    input wire logic i_susp_ok,
    input wire logic i_suspended,
    input wire logic [3:0] i_dummy_cfg,
    output logic o_rd_req,
    output sfd_pkg::sfd_ref_s o_rd,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_valid,
    output sfd_pkg::sfd_byte_s o_wr,
    input wire logic i_wr_ready,
    output logic o_cmd_valid,
    output sfd_pkg::sfd_cmd_s o_cmd,
    output logic o_suspend,
    output logic o_resume
);
    // Pin synchronisers and edge history
    logic sck_s1, sck_s2, sck_d, cs_s1, cs_s2, cs_d;
    logic [3:0] io_s1, io_s2;
    // Selection state
    sfd_pkg::sfd_phase_e ph_q;
    sfd_pkg::sfd_info_s info_q;
    logic [7:0] op_q;
    logic [23:0] sr_q, addr_q;
    logic [4:0] bitc_q;
    logic [2:0] bits_q; // Clocks since select, modulo eight
    logic [3:0] dcnt_q;
    logic [8:0] nb_q, nout_q;
    // Output shifter
    logic [7:0] osr_q;
    logic [2:0] obit_q;
    // Buffer and pending byte
    sfd_pkg::sfd_byte_s buf_q [2];
    sfd_pkg::sfd_byte_s pend_val_q;
    logic pend_q, ovr_q, wp_q, rp_q;
    logic [1:0] cnt_q;

    // Build one decode entry
    function automatic sfd_pkg::sfd_info_s mk(input sfd_pkg::sfd_class_e c,
        input logic arr, input logic ha, input logic [2:0] al, input logic [3:0] dm,
        input logic [2:0] dl, input logic ub, input logic [8:0] mn, input logic [8:0] mx);
        sfd_pkg::sfd_info_s r;
        r = '{cls: c, array: arr, has_addr: ha, addr_ln: al, dummy: dm,
              data_ln: dl, unbounded: ub, min_b: mn, max_b: mx};
        return r;
    endfunction

    // Opcode table, used by the sequencer and the checks
    function automatic sfd_pkg::sfd_info_s info_of(input logic [7:0] op);
        sfd_pkg::sfd_info_s r;
        r = mk(sfd_pkg::SFD_CL_NONE, 1'b0, 1'b0, 3'd1, 4'h0, 3'd1, 1'b0, 9'h000, 9'h000);
        // Low bit of the identification opcode is don't-care
        if ({op[7:1], 1'b0} == `SFD_OP_ID_READ) begin
            r = mk(sfd_pkg::SFD_CL_READ, 1'b0, 1'b0, 3'd1, 4'h0, 3'd1, 1'b0, 9'h001,
                   `SFD_ID_BYTES);
        end else begin
            case (op)
                `SFD_OP_READ: r = mk(sfd_pkg::SFD_CL_READ, 1'b1, 1'b1, 3'd1, 4'h0, 3'd1,
                    1'b1, 9'h001, 9'h000);
                `SFD_OP_FAST_READ: r = mk(sfd_pkg::SFD_CL_READ, 1'b1, 1'b1, 3'd1,
                    `SFD_DUMMY_STD, 3'd1, 1'b1, 9'h001, 9'h000);
                `SFD_OP_DUAL_OUT_RD: r = mk(sfd_pkg::SFD_CL_READ, 1'b1, 1'b1, 3'd1,
                    `SFD_DUMMY_STD, 3'd2, 1'b1, 9'h001, 9'h000);
                `SFD_OP_DUAL_IO_RD: r = mk(sfd_pkg::SFD_CL_READ, 1'b1, 1'b1, 3'd2,
                    `SFD_DUMMY_STD, 3'd2, 1'b1, 9'h001, 9'h000);
                `SFD_OP_QUAD_OUT_RD: r = mk(sfd_pkg::SFD_CL_READ, 1'b1, 1'b1, 3'd1,
                    `SFD_DUMMY_STD, 3'd4, 1'b1, 9'h001, 9'h000);
                `SFD_OP_QUAD_IO_RD: r = mk(sfd_pkg::SFD_CL_READ, 1'b1, 1'b1, 3'd4,
                    `SFD_DUMMY_QIO, 3'd4, 1'b1, 9'h001, 9'h000);
                `SFD_OP_OTP_READ: r = mk(sfd_pkg::SFD_CL_READ, 1'b1, 1'b1, 3'd1,
                    `SFD_DUMMY_STD, 3'd1, 1'b0, 9'h001, `SFD_OTP_BYTES);
                `SFD_OP_LATCH_SET, `SFD_OP_LATCH_CLR, `SFD_OP_FLAG_CLR: r = mk(
                    sfd_pkg::SFD_CL_MOD, 1'b0, 1'b0, 3'd1, 4'h0, 3'd1, 1'b0, 9'h000,
                    9'h000);
                `SFD_OP_PAGE_PROG, `SFD_OP_DUAL_PROG, `SFD_OP_QUAD_PROG: r = mk(
                    sfd_pkg::SFD_CL_MOD, 1'b1, 1'b1, 3'd1, 4'h0,
                    (op == `SFD_OP_PAGE_PROG) ? 3'd1 : (op == `SFD_OP_DUAL_PROG) ? 3'd2 : 3'd4,
                    1'b0, 9'h001, `SFD_PAGE_BYTES);
                `SFD_OP_DUAL_EXT_PROG: r = mk(sfd_pkg::SFD_CL_MOD, 1'b1, 1'b1, 3'd2, 4'h0,
                    3'd2, 1'b0, 9'h001, `SFD_PAGE_BYTES);
                `SFD_OP_QUAD_EXT_PROG: r = mk(sfd_pkg::SFD_CL_MOD, 1'b1, 1'b1, 3'd4, 4'h0,
                    3'd4, 1'b0, 9'h001, `SFD_PAGE_BYTES);
                `SFD_OP_OTP_PROG: r = mk(sfd_pkg::SFD_CL_MOD, 1'b1, 1'b1, 3'd1, 4'h0,
                    3'd1, 1'b0, 9'h001, `SFD_OTP_BYTES);
                `SFD_OP_SMALL_ERASE, `SFD_OP_BLOCK_ERASE: r = mk(sfd_pkg::SFD_CL_MOD, 1'b1,
                    1'b1, 3'd1, 4'h0, 3'd1, 1'b0, 9'h000, 9'h000);
                `SFD_OP_CHIP_ERASE: r = mk(sfd_pkg::SFD_CL_MOD, 1'b1, 1'b0, 3'd1, 4'h0,
                    3'd1, 1'b0, 9'h000, 9'h000);
                `SFD_OP_RESUME: r = mk(sfd_pkg::SFD_CL_RES, 1'b0, 1'b0, 3'd1, 4'h0, 3'd1,
                    1'b0, 9'h000, 9'h000);
                `SFD_OP_SUSPEND: r = mk(sfd_pkg::SFD_CL_SUSP, 1'b0, 1'b0, 3'd1, 4'h0,
                    3'd1, 1'b0, 9'h000, 9'h000);
                `SFD_OP_STAT_RD, `SFD_OP_FLAG_RD, `SFD_OP_VCFG_RD, `SFD_OP_VECFG_RD: r = mk(
                    sfd_pkg::SFD_CL_READ, 1'b0, 1'b0, 3'd1, 4'h0, 3'd1, 1'b1, 9'h001,
                    9'h000);
                `SFD_OP_STAT_WR, `SFD_OP_VCFG_WR, `SFD_OP_VECFG_WR: r = mk(
                    sfd_pkg::SFD_CL_MOD, 1'b0, 1'b0, 3'd1, 4'h0, 3'd1, 1'b0, 9'h001,
                    9'h001);
                `SFD_OP_LOCK_RD: r = mk(sfd_pkg::SFD_CL_READ, 1'b0, 1'b1, 3'd1, 4'h0,
                    3'd1, 1'b1, 9'h001, 9'h000);
                `SFD_OP_LOCK_WR: r = mk(sfd_pkg::SFD_CL_MOD, 1'b0, 1'b1, 3'd1, 4'h0,
                    3'd1, 1'b0, 9'h001, 9'h001);
                `SFD_OP_NVCFG_RD: r = mk(sfd_pkg::SFD_CL_READ, 1'b0, 1'b0, 3'd1, 4'h0,
                    3'd1, 1'b0, `SFD_NVCFG_BYTES, `SFD_NVCFG_BYTES);
                `SFD_OP_NVCFG_WR: r = mk(sfd_pkg::SFD_CL_MOD, 1'b0, 1'b0, 3'd1, 4'h0,
                    3'd1, 1'b0, `SFD_NVCFG_BYTES, `SFD_NVCFG_BYTES);
                default: r = r;
            endcase
        end
        return r;
    endfunction

    // Shift lanes in, highest lane is the more significant bit
    function automatic logic [23:0] shl(input logic [23:0] s, input logic [3:0] io,
        input logic [2:0] ln);
        case (ln)
            3'd2: shl = {s[21:0], io[1:0]};
            3'd4: shl = {s[19:0], io[3:0]};
            default: shl = {s[22:0], io[0]};
        endcase
    endfunction

    // Two flops on every pin, third stage only for edges
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            {sck_s1, sck_s2, sck_d} <= 3'h0;
            {cs_s1, cs_s2, cs_d} <= 3'h7;
            io_s1 <= 4'h0;
            io_s2 <= 4'h0;
        end else begin
            sck_s1 <= i_sck;
            sck_s2 <= sck_s1;
            sck_d <= sck_s2;
            cs_s1 <= i_cs_n;
            cs_s2 <= cs_s1;
            cs_d <= cs_s2;
            io_s1 <= i_io;
            io_s2 <= io_s1;
        end
    end

    // Edge events; the serial clock must be well below i_clk / 4
    logic rise, fall, desel, op_done, byte_done;
    logic [2:0] ln_now;
    logic [4:0] bitc_nx;
    logic [7:0] op_now;
    logic [23:0] sr_nx;
    sfd_pkg::sfd_info_s info_now;
    logic accept;
    logic [3:0] dummy_now;
    sfd_pkg::sfd_phase_e data_ph, after_op;

    assign rise = sck_s2 & ~sck_d & ~cs_s2;
    assign fall = ~sck_s2 & sck_d & ~cs_s2;
    assign desel = cs_s2 & ~cs_d;
    assign ln_now = (ph_q == sfd_pkg::SFD_PH_ADDR) ? info_q.addr_ln : info_q.data_ln;
    assign sr_nx = shl(sr_q, io_s2, (ph_q == sfd_pkg::SFD_PH_OP) ? 3'd1 : ln_now);
    assign bitc_nx = bitc_q + {2'b00, ln_now};
    assign op_now = sr_nx[7:0];
    assign info_now = info_of(op_now);
    assign op_done = rise && ph_q == sfd_pkg::SFD_PH_OP && bitc_q == 5'd7;
    assign byte_done = rise && ph_q == sfd_pkg::SFD_PH_DIN && bitc_nx == 5'd8;
    // While busy only suspend and the two polls get through
    assign accept = info_now.cls != sfd_pkg::SFD_CL_NONE && (!i_busy ||
        op_now == `SFD_OP_SUSPEND || op_now == `SFD_OP_STAT_RD ||
        op_now == `SFD_OP_FLAG_RD);
    assign dummy_now = (info_now.dummy != 4'h0 && i_dummy_cfg != 4'h0) ? i_dummy_cfg :
        info_now.dummy;
    assign data_ph = (info_q.cls == sfd_pkg::SFD_CL_READ) ? sfd_pkg::SFD_PH_DOUT :
        sfd_pkg::SFD_PH_DIN;
    assign after_op = !accept ? sfd_pkg::SFD_PH_SKIP :
        info_now.has_addr ? sfd_pkg::SFD_PH_ADDR :
        (info_now.cls == sfd_pkg::SFD_CL_READ) ? sfd_pkg::SFD_PH_DOUT :
        sfd_pkg::SFD_PH_DIN;

    // Input sequencer on rising serial clock
    always_ff @(posedge i_clk) begin
        if (i_rst || desel) begin
            ph_q <= sfd_pkg::SFD_PH_OP;
            bitc_q <= 5'h00;
            bits_q <= 3'h0;
            sr_q <= 24'h000000;
            op_q <= 8'h00;
            info_q <= '0;
            nb_q <= 9'h000;
            dcnt_q <= 4'h0;
            addr_q <= 24'h000000;
        end else if (rise) begin
            bits_q <= bits_q + 3'h1;
            case (ph_q)
                sfd_pkg::SFD_PH_OP: begin
                    sr_q <= sr_nx;
                    bitc_q <= bitc_q + 5'h01;
                    if (bitc_q == 5'd7) begin
                        op_q <= op_now;
                        info_q <= info_now;
                        bitc_q <= 5'h00;
                        dcnt_q <= dummy_now;
                        ph_q <= after_op;
                    end
                end
                sfd_pkg::SFD_PH_ADDR: begin
                    sr_q <= sr_nx;
                    bitc_q <= bitc_nx;
                    if (bitc_nx == `SFD_ADDR_BITS) begin
                        addr_q <= sr_nx;
                        bitc_q <= 5'h00;
                        ph_q <= (dcnt_q != 4'h0) ? sfd_pkg::SFD_PH_DUMMY : data_ph;
                    end
                end
                sfd_pkg::SFD_PH_DUMMY: begin
                    // Dummy clocks carry nothing
                    dcnt_q <= dcnt_q - 4'h1;
                    if (dcnt_q == 4'h1) begin
                        ph_q <= data_ph;
                    end
                end
                sfd_pkg::SFD_PH_DIN: begin
                    sr_q <= sr_nx;
                    bitc_q <= byte_done ? 5'h00 : bitc_nx;
                    if (byte_done && nb_q != 9'h1ff) begin
                        nb_q <= nb_q + 9'h001;
                    end
                end
                default: begin
                    // Output phase and skipped selections hold still
                    ph_q <= ph_q;
                end
            endcase
        end
    end

    // Output shifter on falling serial clock
    logic [7:0] obyte;
    assign obyte = (obit_q == 3'h0) ? i_rd_data : osr_q;
    always_ff @(posedge i_clk) begin
        if (i_rst || cs_s2) begin
            o_io_out <= 4'h0;
            o_io_oe <= 4'h0;
            osr_q <= 8'h00;
            obit_q <= 3'h0;
            nout_q <= 9'h000;
            o_rd_req <= 1'b0;
        end else begin
            o_rd_req <= 1'b0;
            if (fall && ph_q == sfd_pkg::SFD_PH_DOUT) begin
                if (!info_q.unbounded && obit_q == 3'h0 && nout_q == info_q.max_b) begin
                    // Fixed-length reads release the lines when done
                    o_io_oe <= 4'h0;
                end else begin
                    case (info_q.data_ln)
                        3'd2: begin
                            o_io_out <= {2'b00, obyte[7:6]};
                            o_io_oe <= 4'h3;
                        end
                        3'd4: begin
                            o_io_out <= obyte[7:4];
                            o_io_oe <= 4'hf;
                        end
                        default: begin
                            o_io_out <= {2'b00, obyte[7], 1'b0};
                            o_io_oe <= 4'h2;
                        end
                    endcase
                    osr_q <= obyte << info_q.data_ln;
                    obit_q <= obit_q + info_q.data_ln;
                    if (obit_q == 3'h0) begin
                        o_rd_req <= 1'b1;
                        nout_q <= nout_q + 9'h001;
                    end
                end
            end
        end
    end
    assign o_rd = '{op: op_q, addr: addr_q, idx: nout_q};

    // Pending byte and two-entry buffer; a byte lost behind a full buffer marks overrun
    logic push, pop;
    assign push = pend_q && cnt_q != 2'd2;
    assign pop = o_wr_valid && i_wr_ready;
    assign o_wr_valid = cnt_q != 2'd0;
    assign o_wr = buf_q[rp_q];
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend_q <= 1'b0;
            pend_val_q <= '0;
            ovr_q <= 1'b0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'd0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            if (byte_done) begin
                pend_q <= 1'b1;
                pend_val_q <= '{at: '{op: op_q, addr: addr_q, idx: nb_q}, data: sr_nx[7:0]};
                if (pend_q && !push) begin
                    ovr_q <= 1'b1;
                end
            end else if (push) begin
                pend_q <= 1'b0;
            end
            if (desel) begin
                ovr_q <= 1'b0;
            end
            if (push) begin
                buf_q[wp_q] <= pend_val_q;
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Verdict at deselect for modify, suspend and resume
    logic cmd_cls, cmd_ok;
    assign cmd_cls = info_q.cls == sfd_pkg::SFD_CL_MOD || info_q.cls == sfd_pkg::SFD_CL_SUSP ||
        info_q.cls == sfd_pkg::SFD_CL_RES;
    assign cmd_ok = bits_q == 3'h0 && ph_q == sfd_pkg::SFD_PH_DIN &&
        nb_q >= info_q.min_b && nb_q <= info_q.max_b && !ovr_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_cmd_valid <= 1'b0;
            o_cmd <= '0;
            o_suspend <= 1'b0;
            o_resume <= 1'b0;
        end else begin
            o_cmd_valid <= desel && cmd_cls && ph_q != sfd_pkg::SFD_PH_OP &&
                ph_q != sfd_pkg::SFD_PH_SKIP;
            o_suspend <= desel && cmd_ok && info_q.cls == sfd_pkg::SFD_CL_SUSP &&
                i_busy && i_susp_ok;
            o_resume <= desel && cmd_ok && info_q.cls == sfd_pkg::SFD_CL_RES &&
                i_suspended;
            if (desel) begin
                o_cmd <= '{op: op_q, addr: addr_q, nbytes: nb_q, ok: cmd_ok};
            end
        end
    end

    // Checks
    a_busy_skip: assert property (@(posedge i_clk) disable iff (i_rst)
        op_done && i_busy && info_now.array |=> ph_q == sfd_pkg::SFD_PH_SKIP)
        else $error("array access taken while busy");
    a_poll_busy: assert property (@(posedge i_clk) disable iff (i_rst)
        op_done && i_busy && op_now == `SFD_OP_STAT_RD |=> ph_q == sfd_pkg::SFD_PH_DOUT)
        else $error("status poll refused while busy");
    a_byte_bound: assert property (@(posedge i_clk) disable iff (i_rst)
        desel && info_q.cls == sfd_pkg::SFD_CL_MOD && ph_q != sfd_pkg::SFD_PH_SKIP &&
        bits_q != 3'h0 |=> o_cmd_valid && !o_cmd.ok)
        else $error("off-boundary modify not rejected");
    a_suspend_gate: assert property (@(posedge i_clk) disable iff (i_rst)
        o_suspend |-> $past(i_busy && i_susp_ok))
        else $error("suspend issued without suspendable cycle");
    a_resume_gate: assert property (@(posedge i_clk) disable iff (i_rst)
        o_resume |-> $past(i_suspended) && o_cmd.op == `SFD_OP_RESUME)
        else $error("resume issued without suspension");
    a_fresh_select: assert property (@(posedge i_clk) disable iff (i_rst)
        desel |=> ph_q == sfd_pkg::SFD_PH_OP && bitc_q == 5'h00 && bits_q == 3'h0)
        else $error("selection state not cleared");
    a_unknown_skip: assert property (@(posedge i_clk) disable iff (i_rst)
        op_done && info_now.cls == sfd_pkg::SFD_CL_NONE |=> ph_q == sfd_pkg::SFD_PH_SKIP)
        else $error("unknown opcode not skipped");
    a_release_lines: assert property (@(posedge i_clk) disable iff (i_rst)
        desel |=> (o_io_oe == 4'h0) [*2])
        else $error("data lines driven after deselect");
    a_busy_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        i_busy && o_cmd_valid |-> o_cmd.op == `SFD_OP_SUSPEND)
        else $error("command passed during internal cycle");
    c_read: cover property (@(posedge i_clk) disable iff (i_rst) o_rd_req);
    c_program: cover property (@(posedge i_clk) disable iff (i_rst)
        o_cmd_valid && o_cmd.ok && o_cmd.nbytes != 9'h000);
    c_suspend: cover property (@(posedge i_clk) disable iff (i_rst) o_suspend);
    c_stall: cover property (@(posedge i_clk) disable iff (i_rst) cnt_q == 2'd2);
endmodule
`default_nettype wire

// ---- tb/sfd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial link, driven by task calls from the bench
module sfd_host_model (
    input wire logic i_clk,
    output logic o_sck,
    output logic o_cs_n,
    output logic [3:0] o_io,
    input wire logic i_miso
);
    logic [7:0] rx_q; // Bits gathered from serial_io1
    // Clock stands low and device idle outside frames
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_io = 4'h0;
    end
    // Four system clocks per level keeps sck well inside the sync limit
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Select, then let the cs sync settle before the first clock
    task automatic start();
        o_cs_n <= 1'b0;
        tick(4);
    endtask
    // Send n clocks of b on serial_io0 only
    task automatic send(input logic [7:0] b, input int n);
        for (int k = 0; k < n; k++) begin
            o_io <= {3'h0, b[7 - (k % 8)]};
            tick(4);
            o_sck <= 1'b1;
            tick(4);
            o_sck <= 1'b0;
        end
    endtask
    // Released lines show the inverse, so a stale value never passes
    task automatic recv(input int n);
        o_io <= ~o_io;
        for (int k = 0; k < n; k++) begin
            tick(4);
            o_sck <= 1'b1;
            tick(2);
            rx_q <= {rx_q[6:0], i_miso};
            tick(2);
            o_sck <= 1'b0;
        end
    endtask
    // Deselect, then leave time for the verdict pulses
    task automatic stop();
        o_io <= ~o_io;
        tick(2);
        o_cs_n <= 1'b1;
        tick(8);
    endtask
endmodule
`default_nettype wire

// ---- tb/test_serial_flash_ext_spi_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sfd_regs.svh"
module test_serial_flash_ext_spi_decoder;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic busy = 1'b0;
    logic susp_ok = 1'b0;
    logic wr_ready = 1'b0;
    logic suspended = 1'b0;
    logic sck, cs_n, wr_valid, cmd_valid, susp_pulse, rd_req, res_pulse;
    sfd_pkg::sfd_ref_s rd;
    logic rd_seen = 1'b0, res_seen = 1'b0; // Latched read and resume pulses
    logic [3:0] io, io_out, io_oe;
    sfd_pkg::sfd_byte_s wr;
    sfd_pkg::sfd_cmd_s cmd;
    logic cmd_seen = 1'b0, cmd_ok = 1'b0, susp_seen = 1'b0; // Latched verdicts
    int failures = 0;
    int num_checks = 0;
    int ticks = 0;
    // Opcode, clocks, then busy, suspendable, cmd, ok, suspend pulse
    localparam logic [16:0] ROWS [9] = '{{8'h06, 4'h8, 5'h06}, {8'h04, 4'h8, 5'h06},
        {8'h06, 4'h9, 5'h04}, {8'h50, 4'h8, 5'h06}, {8'hc7, 4'h8, 5'h06},
        {8'h75, 4'h8, 5'h1f}, {8'h75, 4'h8, 5'h16}, {8'hff, 4'h8, 5'h00},
        {8'h06, 4'h8, 5'h10}};
    localparam logic [7:0] POLL [2] = '{`SFD_OP_STAT_RD, `SFD_OP_FLAG_RD};
    localparam logic [7:0] PROG [6] = '{`SFD_OP_PAGE_PROG, 8'h12, 8'h34, 8'h56, 8'h3c, 8'hc3};
    // Last byte only spends the eight default dummy clocks
    localparam logic [7:0] FAST [5] = '{`SFD_OP_FAST_READ, 8'h12, 8'h34, 8'h56, 8'h00};
    sfd_decoder dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_io(io),
        .o_io_out(io_out), .o_io_oe(io_oe), .i_busy(busy), .i_susp_ok(susp_ok),
        .i_suspended(suspended), .i_dummy_cfg(4'h0), .o_rd_req(rd_req), .o_rd(rd),
        .i_rd_data(8'ha5), .o_wr_valid(wr_valid), .o_wr(wr), .i_wr_ready(wr_ready),
        .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_suspend(susp_pulse), .o_resume(res_pulse)
    );
    sfd_host_model host_u (
        // A released line shows the inverse, so a stale bit never passes
        .i_clk(i_clk), .o_sck(sck), .o_cs_n(cs_n), .o_io(io),
        .i_miso(io_oe[1] ? io_out[1] : ~io_out[1])
    );
    initial forever #50 i_clk = ~i_clk;
    // Pulses last one cycle, so latch them for later comparison
    always @(posedge i_clk) begin
        if (cmd_valid === 1'b1) begin
            cmd_seen <= 1'b1;
            cmd_ok <= cmd.ok;
        end
        if (susp_pulse === 1'b1) susp_seen <= 1'b1;
        if (rd_req === 1'b1) rd_seen <= 1'b1;
        if (res_pulse === 1'b1) res_seen <= 1'b1;
    end
    // Hang guard, far above the two thousand or so cycles needed
    always @(posedge i_clk) begin
        ticks <= ticks + 1;
        if (ticks == 20000) begin
            failures = failures + 1;
            summarize();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic summarize();
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        foreach (ROWS[r]) begin
            busy <= ROWS[r][4];
            susp_ok <= ROWS[r][3];
            cmd_seen <= 1'b0;
            susp_seen <= 1'b0;
            host_u.start();
            host_u.send(ROWS[r][16:9], int'(ROWS[r][8:5]));
            host_u.stop();
            chk("cmd", ROWS[r][2], cmd_seen);
            if (ROWS[r][2]) chk("ok", ROWS[r][1], cmd_ok);
            chk("suspend", ROWS[r][0], susp_seen);
        end
        // Polling reads while busy, cut short mid-byte
        busy <= 1'b1;
        foreach (POLL[p]) begin
            cmd_seen <= 1'b0;
            host_u.start();
            host_u.send(POLL[p], 8);
            host_u.recv(8);
            chk("rx", 8'ha5, host_u.rx_q);
            chk("oe", 4'h2, io_oe);
            host_u.recv(3);
            host_u.stop();
            chk("oe_off", 4'h0, io_oe);
            chk("read_cmd", 1'b0, cmd_seen);
        end
        busy <= 1'b0;
        // Page program with the consumer stalled, both words kept
        host_u.start();
        foreach (PROG[b]) host_u.send(PROG[b], 8);
        host_u.stop();
        chk("wr0", {24'h123456, 8'h3c}, {wr.at.addr, wr.data});
        chk("valid", 1'b1, wr_valid);
        chk("prog_ok", 1'b1, cmd_ok);
        chk("nbytes", 9'h002, cmd.nbytes);
        wr_ready <= 1'b1;
        @(posedge i_clk);
        wr_ready <= 1'b0;
        @(posedge i_clk);
        chk("wr1", {9'h001, 8'hc3}, {wr.at.idx, wr.data});
        // Mid-run reset drops the word still waiting in the buffer
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk("rst_valid", 1'b0, wr_valid);
        chk("rst_nbytes", 9'h000, cmd.nbytes);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        // Fast read: address, default dummies, then data on serial_io1
        rd_seen <= 1'b0;
        host_u.start();
        foreach (FAST[b]) host_u.send(FAST[b], 8);
        host_u.recv(8);
        chk("fast_rx", 8'ha5, host_u.rx_q);
        chk("rd_at", {`SFD_OP_FAST_READ, 24'h123456}, {rd.op, rd.addr});
        chk("rd_idx", 9'h001, rd.idx);
        chk("rd_req", 1'b1, rd_seen);
        host_u.stop();
        // Resume with a cycle standing suspended
        suspended <= 1'b1;
        host_u.start();
        host_u.send(`SFD_OP_RESUME, 8);
        host_u.stop();
        chk("resume", 1'b1, res_seen);
        chk("res_ok", 1'b1, cmd_ok);
        summarize();
    end
endmodule
`default_nettype wire
